/* File: src/ldes_pkg.sv */
// ****************************************************************
// shared constants of the loop converter error and status registers
// ****************************************************************
package ldes_pkg;

    // serial frame layout: rw flag, 7-bit address, 16-bit data
    localparam int FRAME_BITS = 24;
    localparam int RW_POS     = 23;
    localparam int ADDR_MSB   = 22;
    localparam int ADDR_LSB   = 16;
    localparam int DATA_MSB   = 15;
    localparam int LVL_MSB    = 15;
    localparam int LVL_LSB    = 8;

    // register addresses
    localparam logic [6:0] ADDR_FIRST    = 7'h01;
    localparam logic [6:0] ADDR_IDLE     = 7'h02;
    localparam logic [6:0] ADDR_UPPER    = 7'h07;
    localparam logic [6:0] ADDR_SRST     = 7'h08;
    localparam logic [6:0] ADDR_STAT     = 7'h09;
    localparam logic [6:0] ADDR_STAT_ALT = 7'h7f;

    // values
    localparam logic [15:0] UPPER_RST = 16'he800;
    localparam logic [15:0] SRST_KEY  = 16'hc33c;
    localparam logic [7:0]  UPPER_MIN = 8'h80;
    localparam logic [7:0]  LOW_ZERO  = 8'h00;
    localparam logic [2:0]  RES_CODE  = 3'h7;
    localparam logic [7:0]  ECHO_PAD  = 8'h00;

    // silence interval unit and the clock rate it is counted at
    localparam int CLK_HZ          = 20_000_000;
    localparam int TIMEOUT_UNIT_MS = 50;
    localparam int UNIT_CYCLES     = TIMEOUT_UNIT_MS * (CLK_HZ / 1000);

    // soft reset arming states
    typedef enum logic [1:0] {
        RS_IDLE  = 2'h1,
        RS_ARMED = 2'h2
    } ldes_rst_state_type;

    // addresses that count as a real register of the map
    function automatic logic addr_valid(input logic [6:0] a);
        addr_valid = ((a >= ADDR_FIRST) && (a <= ADDR_STAT)) || (a == ADDR_STAT_ALT);
    endfunction

    // either status alias
    function automatic logic addr_is_status(input logic [6:0] a);
        addr_is_status = (a == ADDR_STAT) || (a == ADDR_STAT_ALT);
    endfunction

endpackage

/* File: src/ldes_spi_rx.sv */
`timescale 1ns/1ps
// ****************************************************************
// serial frame receiver and readback shifter, oversampled by clk
// ****************************************************************
module ldes_spi_rx (
    input  wire logic                               clk,        // system clock
    input  wire logic                               nrst,       // async reset, low
    input  wire logic                               ce,         // clock enable
    input  wire logic                               cs_n,       // chip select pin, low
    input  wire logic                               sclk,       // serial clock pin
    input  wire logic                               sdi,        // serial data pin
    input  wire logic [ldes_pkg::FRAME_BITS-1:0]    rd_word,    // word for next frame
    input  wire logic                               rd_load,    // load rd_word
    output logic                                    frame_done, // pulse at frame end
    output logic                                    frame_ok,   // length multiple of 24
    output logic      [ldes_pkg::FRAME_BITS-1:0]    frame_word, // last 24 bits seen
    output logic                                    sdo         // serial data out
);
    import ldes_pkg::*;

    localparam int NSYNC = 3;
    localparam logic [4:0] CNT_LAST = 5'(FRAME_BITS - 1);
    localparam logic [4:0] CNT_ZERO = 5'h00;

    logic [NSYNC-1:0]      meta_r;
    logic [NSYNC-1:0]      sync_r;
    logic [NSYNC-1:0]      prev_r;
    logic [4:0]            cnt_r;
    logic                  got_r;
    logic [FRAME_BITS-1:0] shift_r;
    logic [FRAME_BITS-1:0] tx_r;
    logic                  done_r;
    logic                  ok_r;
    logic [FRAME_BITS-1:0] word_r;

    // bit 0 select, bit 1 clock, bit 2 data
    wire cs_act   = !sync_r[0];
    wire cs_fall  = !sync_r[0] && prev_r[0];
    wire cs_rise  = sync_r[0] && !prev_r[0];
    wire clk_rise = cs_act && sync_r[1] && !prev_r[1];
    wire clk_fall = cs_act && !sync_r[1] && prev_r[1];

    // pins come from the host domain: two flops before any logic
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '1;
            sync_r <= '1;
            prev_r <= '1;
        end else if (ce) begin
            meta_r <= {sdi, sclk, cs_n};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // count modulo 24 so any whole multiple closes cleanly
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r   <= CNT_ZERO;
            got_r   <= 1'b0;
            shift_r <= '0;
        end else if (ce) begin
            if (cs_fall) begin
                cnt_r <= CNT_ZERO;
                got_r <= 1'b0;
            end else if (clk_rise) begin
                cnt_r   <= (cnt_r == CNT_LAST) ? CNT_ZERO : cnt_r + 5'h01;
                got_r   <= 1'b1;
                shift_r <= {shift_r[FRAME_BITS-2:0], sync_r[2]};
            end
        end
    end

    // frame result registered at select release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_r <= 1'b0;
            ok_r   <= 1'b0;
            word_r <= '0;
        end else if (ce) begin
            done_r <= cs_rise;
            if (cs_rise) begin
                ok_r   <= got_r && (cnt_r == CNT_ZERO);
                word_r <= shift_r;
            end
        end
    end

    // readback shifts on falling edges, so the host samples just before each fall
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_r <= '0;
        end else if (ce) begin
            if (rd_load) begin
                tx_r <= rd_word;
            end else if (clk_fall) begin
                tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
            end
        end
    end

    assign frame_done = done_r;
    assign frame_ok   = ok_r;
    assign frame_word = word_r;
    assign sdo        = tx_r[FRAME_BITS-1];

endmodule

/* File: src/ldes_regs.sv */
`timescale 1ns/1ps
module ldes_regs #(
    parameter int TIMEOUT_UNIT_CYCLES = ldes_pkg::UNIT_CYCLES  // cycles per 50 ms
) (
    input  wire logic        clk,                   // 20 MHz clock
    input  wire logic        nrst,                  // async reset, low
    input  wire logic        ce,                    // clock enable, freezes state
    input  wire logic        spi_cs_n,              // serial select pin, low
    input  wire logic        spi_sclk,              // serial clock pin
    input  wire logic        spi_sdi,               // serial data in pin
    output logic             spi_sdo,               // serial data out pin
    input  wire logic        error_band_select_pin, // strap, high = upper band
    input  wire logic        loop_fault_in,         // analog loop fault, async
    input  wire logic [15:0] commanded_code,        // normal output code
    input  wire logic [7:0]  lower_level_byte,      // lower error level byte
    input  wire logic [2:0]  timeout_sel,           // silence interval setting
    input  wire logic        silence_report_mask,   // inhibit silence reporting
    input  wire logic        silence_code_mask,     // silence leaves code alone
    input  wire logic        retry_disable,         // hold error until status read
    output logic      [15:0] output_code,           // code to the converter
    output logic             fault_output_n,        // fault pin, low = fault
    output logic             soft_reset_pulse       // resets other registers
);
    import ldes_pkg::*;

    localparam int TW = $clog2(TIMEOUT_UNIT_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TIMEOUT_UNIT_CYCLES - 1);
    localparam logic [TW-1:0] TICK_ZERO = '0;

    logic [1:0]            strap_sync_r;
    logic [1:0]            loop_sync_r;
    logic [15:0]           upper_r;
    logic [15:0]           upper_nxt;
    ldes_rst_state_type    rst_state_r;
    ldes_rst_state_type    rst_state_nxt;
    logic                  frame_sticky_r;
    logic                  loop_sticky_r;
    logic                  silent_r;
    logic                  loop_hold_r;
    logic [TW-1:0]         tick_r;
    logic [2:0]            unit_r;
    logic [15:0]           code_r;
    logic                  fault_n_r;
    logic                  srst_r;
    logic                  frame_done;
    logic                  frame_ok;
    logic [FRAME_BITS-1:0] frame_word;

    // ****************************************************************
    // frame decode
    // ****************************************************************
    wire [6:0]  f_addr     = frame_word[ADDR_MSB:ADDR_LSB];
    wire [15:0] f_data     = frame_word[DATA_MSB:0];
    wire [7:0]  f_level    = f_data[LVL_MSB:LVL_LSB];
    wire        f_read     = frame_word[RW_POS];
    wire        good_frame = frame_done && frame_ok;
    wire        any_write  = good_frame && !f_read;
    wire        valid_wr   = any_write && addr_valid(f_addr);
    wire        wr_upper   = any_write && (f_addr == ADDR_UPPER);
    wire        wr_key     = any_write && (f_addr == ADDR_SRST) && (f_data == SRST_KEY);
    wire        wr_idle    = any_write && (f_addr == ADDR_IDLE);
    // status is only read, a write there stores nothing
    wire        stat_read  = good_frame && f_read && addr_is_status(f_addr);
    wire        rd_any     = good_frame && f_read;
    wire        strap_s    = strap_sync_r[1];
    wire        loop_live  = loop_sync_r[1];
    wire        frame_set  = frame_done && !frame_ok;
    wire        tick_end   = (tick_r == TICK_LAST);
    wire        expire     = tick_end && (unit_r == timeout_sel);
    wire        do_srst    = (rst_state_r == RS_ARMED) && wr_idle;

    // live fault unlatched in bit 0
    wire [7:0]  status_w = {RES_CODE, strap_s, frame_sticky_r, silent_r, loop_sticky_r,
                            loop_live};

    // readback echo of the request followed by the register
    wire [15:0] rd_val   = addr_is_status(f_addr) ? {ECHO_PAD, status_w} :
                           (f_addr == ADDR_UPPER) ? upper_r : '0;
    wire [FRAME_BITS-1:0] rd_word = {frame_word[RW_POS:ADDR_LSB], rd_val};

    // ****************************************************************
    // serial receiver
    // ****************************************************************
    ldes_spi_rx u_rx (
        .clk        (clk),
        .nrst       (nrst),
        .ce         (ce),
        .cs_n       (spi_cs_n),
        .sclk       (spi_sclk),
        .sdi        (spi_sdi),
        .rd_word    (rd_word),
        .rd_load    (rd_any),
        .frame_done (frame_done),
        .frame_ok   (frame_ok),
        .frame_word (frame_word),
        .sdo        (spi_sdo)
    );

    // strap and fault come from outside, two flops each
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_sync_r <= '0;
            loop_sync_r  <= '0;
        end else if (ce) begin
            strap_sync_r <= {strap_sync_r[0], error_band_select_pin};
            loop_sync_r  <= {loop_sync_r[0], loop_fault_in};
        end
    end

    // ****************************************************************
    // upper error level and soft reset
    // ****************************************************************
    // reset key arms, the next write fires if it is an idle write
    // idle write alone changes no setting
    assign rst_state_nxt = !any_write ? rst_state_r :
                           wr_key     ? RS_ARMED    : RS_IDLE;

    // values below the minimum keep the old level
    assign upper_nxt = do_srst                         ? UPPER_RST :
                       (wr_upper && f_level >= UPPER_MIN) ? {f_level, LOW_ZERO} : upper_r;

    // power-on default of the upper level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            upper_r     <= UPPER_RST;
            rst_state_r <= RS_IDLE;
            srst_r      <= 1'b0;
        end else if (ce) begin
            upper_r     <= upper_nxt;
            rst_state_r <= rst_state_nxt;
            srst_r      <= do_srst;
        end
    end

    // ****************************************************************
    // sticky status flags
    // ****************************************************************
    // bad length sets, status read clears, set wins
    // any live fault since last read sets
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_sticky_r <= 1'b0;
            loop_sticky_r  <= 1'b0;
        end else if (ce) begin
            frame_sticky_r <= frame_set || (frame_sticky_r && !stat_read);
            loop_sticky_r  <= loop_live || (loop_sticky_r && !stat_read);
        end
    end

    // with retry off the error stays until a status read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loop_hold_r <= 1'b0;
        end else if (ce) begin
            loop_hold_r <= retry_disable && (loop_live || (loop_hold_r && !stat_read));
        end
    end

    // ****************************************************************
    // link silence timer
    // ****************************************************************
    // trade-off: a short tick counter plus a 3-bit unit count, no wide span compare
    // counts whole 50 ms units up to setting plus one
    // every write restarts it, idle writes included
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_r <= TICK_ZERO;
            unit_r <= '0;
        end else if (ce) begin
            if (any_write || expire) begin
                tick_r <= TICK_ZERO;
                unit_r <= '0;
            end else if (tick_end) begin
                tick_r <= TICK_ZERO;
                unit_r <= unit_r + 3'h1;
            end else begin
                tick_r <= tick_r + 1'b1;
            end
        end
    end

    // expiry sets, only a valid write clears, expiry wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            silent_r <= 1'b0;
        end else if (ce) begin
            silent_r <= expire || (silent_r && !valid_wr);
        end
    end

    // ****************************************************************
    // output code and fault pin
    // ****************************************************************
    // loop errors always count, silence only when unmasked
    // limitation: with retry on the code just follows the live fault, no retry timer
    wire err_now  = loop_live || loop_hold_r ||
                    (silent_r && !silence_report_mask && !silence_code_mask);
    // upper band replaces the code with level and zero low byte
    wire [15:0] code_nxt = !err_now ? commanded_code :
                           strap_s  ? {upper_r[LVL_MSB:LVL_LSB], LOW_ZERO} :
                                      {lower_level_byte, LOW_ZERO};

    // unmasked silence pulls the fault pin low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_r    <= '0;
            fault_n_r <= 1'b1;
        end else if (ce) begin
            code_r    <= code_nxt;
            fault_n_r <= !(silent_r && !silence_report_mask);
        end
    end

    assign output_code      = code_r;
    assign fault_output_n   = fault_n_r;
    assign soft_reset_pulse = srst_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    err_code_a: assert property (ce && err_now && strap_s |=>
        output_code == {$past(upper_r[LVL_MSB:LVL_LSB]), LOW_ZERO})
        else $error("error code not upper level");
    upper_reject_a: assert property (ce && wr_upper && f_level < UPPER_MIN |=>
        upper_r == $past(upper_r))
        else $error("low upper level accepted");
    upper_reset_a: assert property (!$past(nrst) |-> upper_r == UPPER_RST)
        else $error("upper level reset value wrong");
    soft_reset_a: assert property (ce && do_srst |=> upper_r == UPPER_RST && soft_reset_pulse)
        else $error("soft reset did not restore");
    res_code_a: assert property (status_w[7:5] == RES_CODE && status_w[0] == loop_live)
        else $error("status constant fields wrong");
    frame_set_a: assert property (ce && frame_set |=> frame_sticky_r)
        else $error("frame fault not set");
    stat_clear_a: assert property (ce && stat_read && !loop_live && !frame_set |=>
        !frame_sticky_r && !loop_sticky_r)
        else $error("status read did not clear");
    silent_keep_a: assert property (ce && silent_r && !valid_wr |=> silent_r)
        else $error("silence fault cleared wrongly");
    fault_pin_a: assert property (ce && silent_r && !silence_report_mask |=>
        !fault_output_n)
        else $error("fault pin not low");
    retry_hold_a: assert property (ce && retry_disable && loop_hold_r && !stat_read |=>
        loop_hold_r)
        else $error("loop error hold dropped");
    silent_set_a: assert property (ce && expire |=> silent_r)
        else $error("silence fault not set");
    // a live fault always lands in the sticky bit
    loop_set_a: assert property (ce && loop_live |=> loop_sticky_r)
        else $error("loop fault not latched");
    // any write restarts the silence timer
    timer_restart_a: assert property (ce && any_write |=>
        tick_r == TICK_ZERO && unit_r == '0)
        else $error("silence timer not restarted");
    // a write to status leaves the level alone
    status_wr_a: assert property (ce && any_write && addr_is_status(f_addr) |=>
        upper_r == $past(upper_r))
        else $error("status write changed a register");
    // the reset pulse only follows an armed idle write
    srst_only_a: assert property (ce && !do_srst |=> !soft_reset_pulse)
        else $error("spurious soft reset pulse");
    // without an error the commanded code passes
    code_pass_a: assert property (ce && !err_now |=>
        output_code == $past(commanded_code))
        else $error("commanded code not passed");

    // ****************************************************************
    // coverage of the main scenarios
    // ****************************************************************
    cov_srst_c:   cover property (ce && do_srst);
    cov_read_c:   cover property (ce && stat_read && frame_sticky_r);
    cov_silent_c: cover property (ce && expire);
    cov_upper_c:  cover property (ce && wr_upper && f_level >= UPPER_MIN);
    cov_hold_c:   cover property (ce && loop_hold_r && stat_read);

endmodule

/* File: test/ldes_spi_host.sv */
`timescale 1ns/1ps
// ****************************************************************
// serial host model driving the register frames
// ****************************************************************
module ldes_spi_host (
    input  wire logic clk,  // bench clock, paces the link
    output logic      cs_n, // select, low during a frame
    output logic      sclk, // link clock, idles high
    output logic      sdi,  // data to the device
    input  wire logic sdo   // data from the device
);
    // link clock stands still high outside frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi  = 1'b0;
    end

    // n bits msb first; sdo taken just before each fall, after it has settled
    task automatic xfer(input int n, input logic [23:0] w, output logic [23:0] r);
        r = '0;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            r    = {r[22:0], sdo};
            sclk = 1'b0;
            sdi  = w[23-i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
        end
        cs_n = 1'b1;
        sdi  = ~sdi; // released line shows no stale value
        repeat (10) @(negedge clk);
    endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the error and status registers
// ****************************************************************
module testbench;
    import ldes_pkg::*;
    localparam int UNIT = 400;  // short stand-in for 50 ms
    localparam int SIL  = 8 * UNIT; // interval with setting 7
    logic        clk, nrst, ce, strap, lf, rdis, msk_t, msk_e;
    logic [15:0] cmd, d;
    logic [7:0]  lvl, low;
    logic [2:0]  tsel;
    logic [31:0] seed;
    wire         cs_n, sclk, sdi, sdo, flt_n, srp;
    wire  [15:0] code;
    int          error_cnt, n_compared, srst_cnt;

    ldes_regs #(.TIMEOUT_UNIT_CYCLES(UNIT)) DUT (
        .clk(clk), .nrst(nrst), .ce(ce), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_sdi(sdi), .spi_sdo(sdo), .error_band_select_pin(strap),
        .loop_fault_in(lf), .commanded_code(cmd), .lower_level_byte(low),
        .timeout_sel(tsel), .silence_report_mask(msk_t), .silence_code_mask(msk_e),
        .retry_disable(rdis), .output_code(code), .fault_output_n(flt_n),
        .soft_reset_pulse(srp));
    ldes_spi_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // count soft reset pulses seen at the pin
    always @(posedge clk) begin
        if (srp === 1'b1) srst_cnt++;
    end

    function automatic logic [23:0] st(input logic s, f, t, ls, ll);
        return {8'h00, 8'h00, RES_CODE, s, f, t, ls, ll};
    endfunction

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input int n, input logic [6:0] a, input logic [15:0] v);
        logic [23:0] w;
        host.xfer(n, {1'b0, a, v}, w);
    endtask

    // read frame, then a read of address zero shifts the answer out
    task automatic rd(input logic [6:0] a, input logic [23:0] exp);
        logic [23:0] w;
        host.xfer(24, {1'b1, a, 16'h0000}, w);
        host.xfer(24, 24'h800000, w);
        check("echo", w[23:16], {16'h0, 1'b1, a});
        check("data", w[15:0], exp);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        tally_and_finish;
    end

    initial begin
        seed = 32'hc49a7ed6;
        error_cnt = 0; n_compared = 0; srst_cnt = 0;
        nrst = 1'b0; ce = 1'b1; strap = 1'b1; lf = 1'b0; rdis = 1'b0;
        msk_t = 1'b0; msk_e = 1'b0;
        tsel = 3'h7;
        cmd = $random(seed) | 16'h0001;
        low = $random(seed);
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check("code", code, cmd);
        check("fault", flt_n, 1'b1);
        // fixed field and strap at both aliases
        for (int i = 0; i < 4; i++) begin
            strap = $random(seed);
            wr(24, ADDR_IDLE, 16'h0000);
            rd(i[0] ? ADDR_STAT_ALT : ADDR_STAT, st(strap, 0, 0, 0, 0));
        end
        // short frame, sticky until read
        strap = 1'b1;
        wr(23, ADDR_IDLE, 16'h0000);
        rd(ADDR_STAT_ALT, st(1, 1, 0, 0, 0));
        rd(ADDR_STAT, st(1, 0, 0, 0, 0));
        rd(7'h0a, 24'h0);
        // upper level: reset value, refusal below the floor, boundary
        wr(24, ADDR_UPPER, 16'h7f00);
        rd(ADDR_UPPER, UPPER_RST);
        // a write to the status register stores nothing
        wr(24, ADDR_STAT, 16'hffff);
        rd(ADDR_STAT, st(1, 0, 0, 0, 0));
        rd(ADDR_UPPER, UPPER_RST);
        lvl = UPPER_MIN;
        for (int i = 0; i < 2; i++) begin
            wr(24, ADDR_UPPER, {lvl, LOW_ZERO});
            rd(ADDR_UPPER, {lvl, LOW_ZERO});
            lvl = {1'b1, 7'($random(seed))};
        end
        wr(24, ADDR_UPPER, {lvl, LOW_ZERO});
        // silence interval and its effects
        repeat (SIL - 40) @(negedge clk);
        check("early", flt_n, 1'b1);
        repeat (80) @(negedge clk);
        check("flt", flt_n, 1'b0);
        check("err", code, {lvl, LOW_ZERO});
        // code mask keeps the commanded code but not the pin
        msk_e = 1'b1;
        repeat (3) @(negedge clk);
        check("cmask", code, cmd);
        check("cpin", flt_n, 1'b0);
        msk_e = 1'b0;
        repeat (3) @(negedge clk);
        check("err2", code, {lvl, LOW_ZERO});
        // lower band strap selects the lower level byte
        strap = 1'b0;
        repeat (5) @(negedge clk);
        check("lowb", code, {low, LOW_ZERO});
        strap = 1'b1;
        repeat (5) @(negedge clk);
        msk_t = 1'b1;
        repeat (3) @(negedge clk);
        check("mask", flt_n, 1'b1);
        msk_t = 1'b0;
        rd(ADDR_STAT, st(1, 0, 1, 0, 0));
        rd(ADDR_STAT, st(1, 0, 1, 0, 0));
        wr(24, ADDR_IDLE, 16'h0000);
        check("clr", flt_n, 1'b1);
        check("back", code, cmd);
        rd(ADDR_UPPER, {lvl, LOW_ZERO});
        // loop fault live and sticky
        lf = 1'b1;
        wr(24, ADDR_IDLE, 16'h0000);
        check("lerr", code, {lvl, LOW_ZERO});
        rd(ADDR_STAT, st(1, 0, 0, 1, 1));
        lf = 1'b0;
        rd(ADDR_STAT, st(1, 0, 0, 1, 0));
        check("retry", code, cmd);
        rd(ADDR_STAT, st(1, 0, 0, 0, 0));
        // retry disabled holds the error code until a status read
        rdis = 1'b1;
        wr(24, ADDR_IDLE, 16'h0000);
        lf = 1'b1;
        repeat (10) @(negedge clk);
        lf = 1'b0;
        repeat (10) @(negedge clk);
        check("hold", code, {lvl, LOW_ZERO});
        rd(ADDR_STAT, st(1, 0, 0, 1, 0));
        repeat (4) @(negedge clk);
        check("rel", code, cmd);
        // soft reset: a write between key and idle disarms
        wr(24, ADDR_SRST, SRST_KEY);
        wr(24, ADDR_UPPER, {lvl, LOW_ZERO});
        wr(24, ADDR_IDLE, 16'h0000);
        check("nosrst", srst_cnt, 0);
        wr(24, ADDR_SRST, SRST_KEY);
        wr(24, ADDR_IDLE, 16'h0000);
        check("srst", srst_cnt, 1);
        rd(ADDR_UPPER, UPPER_RST);
        // shorter interval setting: two units
        tsel = 3'h1;
        wr(24, ADDR_IDLE, 16'h0000);
        repeat (2 * UNIT - 40) @(negedge clk);
        check("early1", flt_n, 1'b1);
        repeat (80) @(negedge clk);
        check("flt1", flt_n, 1'b0);
        tally_and_finish;
    end
endmodule
